// *** occr_pkg.sv ***
package occr_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam int          NUM_REGS       = 8;
  localparam logic [7:0]  OFS_OUT2_STD   = 8'h25;
  localparam logic [7:0]  OFS_DIV_HIGH   = 8'h28;
  localparam logic [7:0]  OFS_DIV_MID    = 8'h29;
  localparam logic [7:0]  OFS_DIV_LOW    = 8'h2a;
  localparam logic [7:0]  OFS_PHASE_STR  = 8'h2b;
  localparam logic [7:0]  OFS_DELAY      = 8'h2c;
  localparam logic [7:0]  OFS_SUPPLY_STD = 8'h2d;
  localparam logic [7:0]  OFS_LEGS_FUSE  = 8'h2f;
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ  = 8'h00;

  // Storage indices
  localparam logic [2:0]  IDX_OUT2_STD   = 3'h0;
  localparam logic [2:0]  IDX_DIV_HIGH   = 3'h1;
  localparam logic [2:0]  IDX_DIV_MID    = 3'h2;
  localparam logic [2:0]  IDX_DIV_LOW    = 3'h3;
  localparam logic [2:0]  IDX_PHASE_STR  = 3'h4;
  localparam logic [2:0]  IDX_DELAY      = 3'h5;
  localparam logic [2:0]  IDX_SUPPLY_STD = 3'h6;
  localparam logic [2:0]  IDX_LEGS_FUSE  = 3'h7;

  // ****************************************
  // Field codes
  // ****************************************
  localparam logic [1:0]  PHASE_NORMAL   = 2'h0;
  localparam logic [1:0]  PHASE_BOTH_T   = 2'h1;
  localparam logic [1:0]  PHASE_BOTH_I   = 2'h2;
  localparam logic [1:0]  PHASE_SWAP     = 2'h3;
  localparam logic [2:0]  FINE_MAX_STEPS = 3'h4;
  localparam logic [7:0]  FINE_STEP_PS   = 8'h1e;
  localparam logic [2:0]  STD_MAX_DEF    = 3'h5;
  localparam logic [1:0]  SUPPLY_MAX_DEF = 2'h2;
  localparam logic [3:0]  LEGS_EXT_TERM  = 4'h0;
  localparam logic [3:0]  LEGS_PULL_DN   = 4'h1;
  localparam logic [3:0]  LEGS_PULL_UP   = 4'h2;
  localparam logic [3:0]  LEGS_CMOS_T    = 4'h4;
  localparam logic [3:0]  LEGS_CMOS_C    = 4'h8;
  localparam logic [3:0]  LEGS_CMOS_BOTH = 4'hc;
  localparam logic [1:0]  FUSE_WR_A      = 2'h1;
  localparam logic [1:0]  FUSE_WR_B      = 2'h2;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int          RATIO_TOP_MSB  = 3;
  localparam int          RATIO_TOP_LSB  = 0;
  localparam int          PHASE_MSB      = 7;
  localparam int          PHASE_LSB      = 6;
  localparam int          STRENGTH_MSB   = 2;
  localparam int          STRENGTH_LSB   = 0;
  localparam int          COARSE_MSB     = 5;
  localparam int          COARSE_LSB     = 0;
  localparam int          FINE_MSB       = 7;
  localparam int          FINE_LSB       = 6;
  localparam int          FINE_EXT_BIT   = 4;
  localparam int          SUPPLY_MSB     = 4;
  localparam int          SUPPLY_LSB     = 3;
  localparam int          STD_MSB        = 2;
  localparam int          STD_LSB        = 0;
  localparam int          FUSE_MSB       = 7;
  localparam int          FUSE_LSB       = 6;
  localparam int          LEGS_MSB       = 3;
  localparam int          LEGS_LSB       = 0;
endpackage

// *** occr_byte_reg.sv ***
`timescale 1ns/1ns
module occr_byte_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] q
);
  always_ff @(posedge clk)
  begin
    if (!nrst)
      q <= RESET_VALUE;
    else if (ce && wr)
      q <= wdata;
  end
endmodule

// *** occr_output_channel_config_regs.sv ***
`timescale 1ns/1ns
module occr_output_channel_config_regs #(
  parameter int DIV_WIDTH = 20
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic                 ce,
  input  wire logic                 wr_en,
  input  wire logic                 rd_en,
  input  wire logic [7:0]           addr,
  input  wire logic [7:0]           wdata,
  output logic      [7:0]           rdata,
  output logic                      rdata_valid,
  output logic      [2:0]           out2_driver_standard,
  output logic      [DIV_WIDTH-1:0] post_divider_ratio,
  output logic                      true_leg_source,
  output logic                      complement_leg_source,
  output logic      [2:0]           drive_strength,
  output logic      [5:0]           coarse_delay,
  output logic      [2:0]           fine_delay_steps,
  output logic      [7:0]           fine_delay_ps,
  output logic      [1:0]           supply_definition,
  output logic                      supply_reserved,
  output logic      [2:0]           driver_standard,
  output logic                      driver_reserved,
  output logic                      fuse_written,
  output logic                      diff_external_term,
  output logic                      diff_pull_up,
  output logic                      diff_pull_down,
  output logic                      true_leg_pin_cmos,
  output logic                      complement_leg_pin_cmos,
  output logic                      legs_reserved
);
  // ****************************************
  // Address decode
  // ****************************************
  wire logic       hit_out2   = (addr == occr_pkg::OFS_OUT2_STD);
  wire logic       hit_high   = (addr == occr_pkg::OFS_DIV_HIGH);
  wire logic       hit_mid    = (addr == occr_pkg::OFS_DIV_MID);
  wire logic       hit_low    = (addr == occr_pkg::OFS_DIV_LOW);
  wire logic       hit_phase  = (addr == occr_pkg::OFS_PHASE_STR);
  wire logic       hit_delay  = (addr == occr_pkg::OFS_DELAY);
  wire logic       hit_supply = (addr == occr_pkg::OFS_SUPPLY_STD);
  wire logic       hit_legs   = (addr == occr_pkg::OFS_LEGS_FUSE);
  wire logic       hit_any    = hit_out2 | hit_high | hit_mid | hit_low | hit_phase | hit_delay | hit_supply | hit_legs;
  wire logic [2:0] idx        = hit_out2   ? occr_pkg::IDX_OUT2_STD   :
                                hit_high   ? occr_pkg::IDX_DIV_HIGH   :
                                hit_mid    ? occr_pkg::IDX_DIV_MID    :
                                hit_low    ? occr_pkg::IDX_DIV_LOW    :
                                hit_phase  ? occr_pkg::IDX_PHASE_STR  :
                                hit_delay  ? occr_pkg::IDX_DELAY      :
                                hit_supply ? occr_pkg::IDX_SUPPLY_STD :
                                             occr_pkg::IDX_LEGS_FUSE;

  // ****************************************
  // Storage
  // ****************************************
  // Every byte stores all eight bits so spares read back as written
  logic [7:0] regs [occr_pkg::NUM_REGS];

  genvar g;
  generate
    for (g = 0; g < occr_pkg::NUM_REGS; g++)
    begin : g_reg
      occr_byte_reg #(
        .RESET_VALUE (occr_pkg::REG_RESET)
      ) u_reg (
        .clk   (clk),
        .nrst  (nrst),
        .ce    (ce),
        .wr    (wr_en && hit_any && (idx == 3'(g))),
        .wdata (wdata),
        .q     (regs[g])
      );
    end
  endgenerate

  wire logic [7:0] r_out2   = regs[occr_pkg::IDX_OUT2_STD];
  wire logic [7:0] r_high   = regs[occr_pkg::IDX_DIV_HIGH];
  wire logic [7:0] r_mid    = regs[occr_pkg::IDX_DIV_MID];
  wire logic [7:0] r_low    = regs[occr_pkg::IDX_DIV_LOW];
  wire logic [7:0] r_phase  = regs[occr_pkg::IDX_PHASE_STR];
  wire logic [7:0] r_delay  = regs[occr_pkg::IDX_DELAY];
  wire logic [7:0] r_supply = regs[occr_pkg::IDX_SUPPLY_STD];
  wire logic [7:0] r_legs   = regs[occr_pkg::IDX_LEGS_FUSE];

  // ****************************************
  // Field extraction
  // ****************************************
  // Bit positions live in the package so a map change touches one file
  wire logic [3:0] f_ratio_top = r_high[occr_pkg::RATIO_TOP_MSB:occr_pkg::RATIO_TOP_LSB];
  wire logic [1:0] f_phase     = r_phase[occr_pkg::PHASE_MSB:occr_pkg::PHASE_LSB];
  wire logic [2:0] f_strength  = r_phase[occr_pkg::STRENGTH_MSB:occr_pkg::STRENGTH_LSB];
  wire logic [5:0] f_coarse    = r_delay[occr_pkg::COARSE_MSB:occr_pkg::COARSE_LSB];
  wire logic [1:0] f_fine_low  = r_delay[occr_pkg::FINE_MSB:occr_pkg::FINE_LSB];
  wire logic       f_fine_ext  = r_legs[occr_pkg::FINE_EXT_BIT];
  wire logic [1:0] f_supply    = r_supply[occr_pkg::SUPPLY_MSB:occr_pkg::SUPPLY_LSB];
  wire logic [2:0] f_std       = r_supply[occr_pkg::STD_MSB:occr_pkg::STD_LSB];
  wire logic [2:0] f_out2_std  = r_out2[occr_pkg::STD_MSB:occr_pkg::STD_LSB];
  wire logic [1:0] f_fuse      = r_legs[occr_pkg::FUSE_MSB:occr_pkg::FUSE_LSB];
  wire logic [3:0] f_legs      = r_legs[occr_pkg::LEGS_MSB:occr_pkg::LEGS_LSB];

  // ****************************************
  // Field decode
  // ****************************************
  // No atomic update: the ratio passes through mixed bytes while software writes
  wire logic [DIV_WIDTH-1:0] next_ratio = DIV_WIDTH'({f_ratio_top, r_mid, r_low});
  // 0 selects true phase, 1 selects inverted phase
  wire logic       next_true_src = (f_phase == occr_pkg::PHASE_BOTH_I) |
                                   (f_phase == occr_pkg::PHASE_SWAP);
  wire logic       next_comp_src = (f_phase == occr_pkg::PHASE_NORMAL) |
                                   (f_phase == occr_pkg::PHASE_BOTH_I);
  wire logic [2:0] fine_code   = {f_fine_ext, f_fine_low};
  // Codes above four saturate rather than wrap, so a bad write never shrinks delay
  wire logic [2:0] next_fine   = (fine_code > occr_pkg::FINE_MAX_STEPS) ? occr_pkg::FINE_MAX_STEPS
                                                                        : fine_code;
  wire logic [7:0] next_fine_ps = 8'(next_fine * occr_pkg::FINE_STEP_PS);
  wire logic [1:0] next_supply = f_supply;
  wire logic [2:0] next_std    = f_std;
  // Either single-bit pattern marks the fuse as written
  wire logic       next_fuse   = (f_fuse == occr_pkg::FUSE_WR_A) |
                                 (f_fuse == occr_pkg::FUSE_WR_B);
  wire logic       next_ext    = (f_legs == occr_pkg::LEGS_EXT_TERM);
  wire logic       next_pu     = (f_legs == occr_pkg::LEGS_PULL_UP);
  wire logic       next_pd     = (f_legs == occr_pkg::LEGS_PULL_DN);
  wire logic       next_cmos_t = (f_legs == occr_pkg::LEGS_CMOS_T) |
                                 (f_legs == occr_pkg::LEGS_CMOS_BOTH);
  wire logic       next_cmos_c = (f_legs == occr_pkg::LEGS_CMOS_C) |
                                 (f_legs == occr_pkg::LEGS_CMOS_BOTH);
  // Undefined codes are flagged only; the analog side decides what to do
  wire logic       next_legs_rsv = ~(next_ext | next_pu | next_pd | next_cmos_t | next_cmos_c);
  wire logic       next_std_rsv  = (next_std > occr_pkg::STD_MAX_DEF);
  wire logic       next_sup_rsv  = (next_supply > occr_pkg::SUPPLY_MAX_DEF);

  // ****************************************
  // Read path
  // ****************************************
  // A read in the cycle of a write to the same byte returns the old value
  wire logic [7:0] next_rdata    = hit_any ? regs[idx] : occr_pkg::UNMAPPED_READ;

  // ****************************************
  // Output flops
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rdata       <= occr_pkg::REG_RESET;
      rdata_valid <= 1'b0;
    end
    else if (ce)
    begin
      rdata_valid <= rd_en;
      if (rd_en)
        rdata <= next_rdata;
    end
  end

  // Decoded settings lag the register write by one cycle
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      out2_driver_standard    <= 3'h0;
      post_divider_ratio      <= '0;
      true_leg_source         <= 1'b0;
      complement_leg_source   <= 1'b0;
      drive_strength          <= 3'h0;
      coarse_delay            <= 6'h00;
      fine_delay_steps        <= 3'h0;
      fine_delay_ps           <= 8'h00;
      supply_definition       <= 2'h0;
      supply_reserved         <= 1'b0;
      driver_standard         <= 3'h0;
      driver_reserved         <= 1'b0;
      fuse_written            <= 1'b0;
      diff_external_term      <= 1'b0;
      diff_pull_up            <= 1'b0;
      diff_pull_down          <= 1'b0;
      true_leg_pin_cmos       <= 1'b0;
      complement_leg_pin_cmos <= 1'b0;
      legs_reserved           <= 1'b0;
    end
    else if (ce)
    begin
      out2_driver_standard    <= f_out2_std;
      post_divider_ratio      <= next_ratio;
      true_leg_source         <= next_true_src;
      complement_leg_source   <= next_comp_src;
      drive_strength          <= f_strength;
      coarse_delay            <= f_coarse;
      fine_delay_steps        <= next_fine;
      fine_delay_ps           <= next_fine_ps;
      supply_definition       <= next_supply;
      supply_reserved         <= next_sup_rsv;
      driver_standard         <= next_std;
      driver_reserved         <= next_std_rsv;
      fuse_written            <= next_fuse;
      diff_external_term      <= next_ext;
      diff_pull_up            <= next_pu;
      diff_pull_down          <= next_pd;
      true_leg_pin_cmos       <= next_cmos_t;
      complement_leg_pin_cmos <= next_cmos_c;
      legs_reserved           <= next_legs_rsv;
    end
  end
endmodule

// *** occr_ocr_props.sv ***
`timescale 1ns/1ns
module occr_ocr_props #(
  parameter int DIV_WIDTH = 20
) (
  input wire logic                 clk,
  input wire logic                 nrst,
  input wire logic                 ce,
  input wire logic                 wr_en,
  input wire logic [7:0]           addr,
  input wire logic [7:0]           wdata,
  input wire logic [DIV_WIDTH-1:0] post_divider_ratio,
  input wire logic                 true_leg_source,
  input wire logic                 complement_leg_source,
  input wire logic [5:0]           coarse_delay,
  input wire logic [2:0]           fine_delay_steps,
  input wire logic [7:0]           fine_delay_ps,
  input wire logic [2:0]           driver_standard,
  input wire logic                 fuse_written,
  input wire logic                 diff_external_term,
  input wire logic                 diff_pull_up,
  input wire logic                 diff_pull_down,
  input wire logic                 true_leg_pin_cmos,
  input wire logic                 complement_leg_pin_cmos,
  input wire logic                 legs_reserved
);
  // ****************************************
  // Write to decoded output, two edges on
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Second cycle needs ce, else the decode stays frozen
  property wr_then(a, ok);
    (ce && wr_en && addr == a) ##1 ce |=> ok;
  endproperty
  a_ratio_low: assert property (wr_then(8'h2a, post_divider_ratio[7:0] == $past(wdata, 2)))
    else $error("Ratio low byte wrong");
  a_ratio_high: assert property (wr_then(8'h28, post_divider_ratio[DIV_WIDTH-1:16] == $past(wdata[3:0], 2)))
    else $error("Ratio high nibble wrong");
  a_phase_route: assert property (wr_then(8'h2b, {true_leg_source, complement_leg_source} == {$past(wdata[7], 2), !$past(wdata[6], 2)}))
    else $error("Leg phase routing wrong");
  a_coarse_delay: assert property (wr_then(8'h2c, coarse_delay == $past(wdata[5:0], 2)))
    else $error("Coarse delay wrong");
  a_driver_std: assert property (wr_then(8'h2d, driver_standard == $past(wdata[2:0], 2)))
    else $error("Driver standard wrong");
  a_fuse_state: assert property (wr_then(8'h2f, fuse_written == ^$past(wdata[7:6], 2)))
    else $error("Fuse indicator wrong");
  a_fine_ps: assert property (fine_delay_ps == 8'(fine_delay_steps * 30))
    else $error("Fine delay picoseconds wrong");
  a_fine_limit: assert property (fine_delay_steps <= 3'h4)
    else $error("Fine steps above four");
  // Skips the first edge after reset, where the decode is still all zero
  a_legs_onehot: assert property ($past(nrst) |-> $onehot({diff_external_term, diff_pull_up, diff_pull_down, true_leg_pin_cmos | complement_leg_pin_cmos, legs_reserved}))
    else $error("Leg arrangement not one-hot");
  c_fine_max: cover property (fine_delay_steps == 3'h4);
  c_cmos_both: cover property (true_leg_pin_cmos && complement_leg_pin_cmos);
  c_fuse: cover property (fuse_written);
endmodule

bind occr_output_channel_config_regs occr_ocr_props #(.DIV_WIDTH(DIV_WIDTH)) i_occr_ocr_props (
  .clk                     (clk),
  .nrst                    (nrst),
  .ce                      (ce),
  .wr_en                   (wr_en),
  .addr                    (addr),
  .wdata                   (wdata),
  .post_divider_ratio      (post_divider_ratio),
  .true_leg_source         (true_leg_source),
  .complement_leg_source   (complement_leg_source),
  .coarse_delay            (coarse_delay),
  .fine_delay_steps        (fine_delay_steps),
  .fine_delay_ps           (fine_delay_ps),
  .driver_standard         (driver_standard),
  .fuse_written            (fuse_written),
  .diff_external_term      (diff_external_term),
  .diff_pull_up            (diff_pull_up),
  .diff_pull_down          (diff_pull_down),
  .true_leg_pin_cmos       (true_leg_pin_cmos),
  .complement_leg_pin_cmos (complement_leg_pin_cmos),
  .legs_reserved           (legs_reserved)
);

// *** occr_output_channel_config_regs_bench.sv ***
`timescale 1ns/1ns
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin n_mismatch++; $display("Error %s expected %h seen %h", n, e, s); end end
module occr_output_channel_config_regs_bench;
  logic        clk = 0, nrst, ce, wr_en, rd_en, rdata_valid, true_leg_source, complement_leg_source;
  logic        supply_reserved, driver_reserved, fuse_written, diff_external_term, diff_pull_up;
  logic        diff_pull_down, true_leg_pin_cmos, complement_leg_pin_cmos, legs_reserved;
  logic [7:0]  addr, wdata, rdata, fine_delay_ps, e, q [$], m [0:255];
  logic [2:0]  out2_driver_standard, drive_strength, fine_delay_steps, driver_standard, st;
  logic [1:0]  supply_definition;
  logic [5:0]  coarse_delay;
  logic [19:0] post_divider_ratio;
  logic [3:0]  lg;
  logic [3:0]  tbl [0:5] = '{4'h0, 4'h2, 4'h1, 4'h4, 4'h8, 4'hc};
  logic [7:0]  ofs [0:8] = '{8'h25, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2f, 8'h26};
  int          seed = 32'h7574f5c8, cyc, n_mismatch, cmp_count;

  occr_output_channel_config_regs i_occr_output_channel_config_regs (
    .clk                     (clk),
    .nrst                    (nrst),
    .ce                      (ce),
    .wr_en                   (wr_en),
    .rd_en                   (rd_en),
    .addr                    (addr),
    .wdata                   (wdata),
    .rdata                   (rdata),
    .rdata_valid             (rdata_valid),
    .out2_driver_standard    (out2_driver_standard),
    .post_divider_ratio      (post_divider_ratio),
    .true_leg_source         (true_leg_source),
    .complement_leg_source   (complement_leg_source),
    .drive_strength          (drive_strength),
    .coarse_delay            (coarse_delay),
    .fine_delay_steps        (fine_delay_steps),
    .fine_delay_ps           (fine_delay_ps),
    .supply_definition       (supply_definition),
    .supply_reserved         (supply_reserved),
    .driver_standard         (driver_standard),
    .driver_reserved         (driver_reserved),
    .fuse_written            (fuse_written),
    .diff_external_term      (diff_external_term),
    .diff_pull_up            (diff_pull_up),
    .diff_pull_down          (diff_pull_down),
    .true_leg_pin_cmos       (true_leg_pin_cmos),
    .complement_leg_pin_cmos (complement_leg_pin_cmos),
    .legs_reserved           (legs_reserved)
  );
  always #2 clk = ~clk;

  // ****************************************
  // Driver and read scoreboard
  // ****************************************
  // One edge per call, so back-to-back calls never reassign a strobe twice
  task acc(input logic c, w, r, input logic [7:0] a, dd);
    @(posedge clk);
    {ce, wr_en, rd_en, addr, wdata} <= {c, w, r, a, dd};
    if (c && r) q.push_back(m[a]);
    if (c && w && a inside {8'h25, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2f}) m[a] = dd;
  endtask

  task close_out;
    $display("Checks %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(negedge clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      n_mismatch++;
      close_out();
    end
    else if (rdata_valid === 1'b1)
    begin
      e = q.pop_front();
      `CHK("rdata", e, rdata)
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    {nrst, ce, wr_en, rd_en, addr, wdata} = {4'b0100, 16'h0};
    m = '{default: 8'h00};
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    acc(1, 0, 0, 0, 0);
    @(negedge clk);
    `CHK("ext_term", 1'b1, diff_external_term)
    foreach (ofs[k]) acc(1, 0, 1, ofs[k], 0);
    for (int i = 0; i < 8; i++)
    begin
      st = 3'(i % 6);
      lg = tbl[i % 6];
      foreach (ofs[k]) acc(1, 1, 0, ofs[k], 8'($random(seed)) & ((ofs[k] inside {8'h2d, 8'h2f}) ? 8'he0 : 8'hff));
      acc(1, 1, 0, 8'h2b, {i[1:0], 3'($random(seed)), 3'h7});
      acc(1, 1, 0, 8'h2c, {i[1:0], 6'($random(seed))});
      acc(1, 1, 0, 8'h2d, {3'($random(seed)), 2'(i % 3), st});
      acc(1, 1, 0, 8'h2f, {i[1:0], 1'($random(seed)), i[2], lg});
      acc(0, 1, 0, 8'h2a, 8'hff);
      acc(1, 0, 0, 0, 0);
      acc(1, 0, 0, 0, 0);
      @(negedge clk);
      `CHK("ratio", {m[8'h28][3:0], m[8'h29], m[8'h2a]}, post_divider_ratio)
      `CHK("phase", {i[1], ~i[0]}, {true_leg_source, complement_leg_source})
      `CHK("coarse", m[8'h2c][5:0], coarse_delay)
      `CHK("strength", 3'h7, drive_strength)
      `CHK("fine", {3'(i > 4 ? 4 : i), 8'(30 * (i > 4 ? 4 : i))}, {fine_delay_steps, fine_delay_ps})
      `CHK("supply", {2'(i % 3), 1'b0}, {supply_definition, supply_reserved})
      `CHK("std", {st, 1'b0, m[8'h25][2:0]}, {driver_standard, driver_reserved, out2_driver_standard})
      `CHK("fuse", ^i[1:0], fuse_written)
      `CHK("legs", {lg == 0, lg == 2, lg == 1, lg[2], lg[3], 1'b0}, {diff_external_term, diff_pull_up, diff_pull_down,
           true_leg_pin_cmos, complement_leg_pin_cmos, legs_reserved})
      foreach (ofs[k]) acc(1, 0, 1, ofs[k], 0);
    end
    repeat (4) acc(1, 0, 0, 0, 0);
    `CHK("pending", 0, q.size())
    close_out();
  end
endmodule
